// ===== core/sixteen_bit_timer_counter.sv
// sixteen-bit timer/counter with apb register access
// assumes a free-running system clock; the analogue oscillator sits outside
// and reports its output level on i_crystal_in_pin
`timescale 1ns/1ps
`include "timer_one_params.svh"
module sixteen_bit_timer_counter
    import timer_one_pkg::*;
#(
    parameter int INSTR_DIV = 4
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // pins and system signals
    input wire logic i_ext_count_clock_pin,
    input wire logic i_crystal_in_pin,
    input wire logic i_compare_module_trigger,
    input wire logic i_sysclk_from_osc,
    input wire logic i_power_managed,
    // oscillator and port control
    output logic o_crystal_osc_run,
    output logic o_osc_pins_force_input,
    output logic o_osc_pins_read_zero,
    // interrupt request
    output logic o_overflow_irq
);
    typedef struct packed {
        logic [7:0] control;
        logic [15:0] count;
        logic [7:0] high_buffer;
        logic flag;
        logic irq_enable;
        logic ext_prev;
        logic [1:0] instr_div;
        logic [31:0] rdata;
        logic rd_wait;
        logic sysclk_status;
    } timer_state_t;

    timer_state_t state_ff;
    timer_state_t nxt_state;

    logic ext_level_sync;
    logic ext_raw;
    logic ext_level;
    logic raw_tick;
    logic pre_tick;
    logic low_wr;
    logic access;
    logic wr;
    logic rd;
    logic addr_ok;
    logic ovf_set;

    // ------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------
    // oscillator output replaces the pin when the oscillator runs
    assign ext_raw = state_ff.control[`BIT_OSC_ENABLE] ? i_crystal_in_pin
                                                       : i_ext_count_clock_pin;

    input_sync3 u_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(ext_raw),
        .o_level(ext_level_sync)
    );

    // bypass still crosses through the synchroniser; a true asynchronous
    // counter would need a second domain, so the bypass bit is ignored
    assign ext_level = ext_level_sync;

    // tick on internal divider or external rising edge
    always_comb
    begin
        if (state_ff.control[`BIT_SOURCE])
        begin
            raw_tick = ext_level && !state_ff.ext_prev;
        end
        else
        begin
            raw_tick = (state_ff.instr_div == 2'(INSTR_DIV - 1));
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    assign rd = access && !i_pwrite;
    assign addr_ok = (i_paddr == `ADDR_CONTROL) || (i_paddr == `ADDR_COUNT_LOW)
                     || (i_paddr == `ADDR_COUNT_HIGH) || (i_paddr == `ADDR_IRQ);
    assign low_wr = wr && (i_paddr == `ADDR_COUNT_LOW);
    // reads take one wait state so registered read data stands at the ready edge
    assign o_pready = !rd || state_ff.rd_wait;
    assign o_pslverr = access && !addr_ok;
    assign o_prdata = state_ff.rdata;

    count_prescaler u_pre
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ratio(prescale_t'(state_ff.control[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO])),
        .i_clear(low_wr),
        .i_tick(raw_tick && state_ff.control[`BIT_RUN]),
        .o_tick(pre_tick)
    );

    // ------------------------------------------------------------------
    // counter, flag and registers
    // ------------------------------------------------------------------
    // rollover this cycle; a trigger clear in the same cycle suppresses it
    assign ovf_set = pre_tick && state_ff.control[`BIT_RUN] && (state_ff.count == 16'hffff)
                     && !i_compare_module_trigger;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.ext_prev = ext_level;
        nxt_state.sysclk_status = i_sysclk_from_osc;
        if (state_ff.instr_div == 2'(INSTR_DIV - 1))
        begin
            nxt_state.instr_div = 2'h0;
        end
        else
        begin
            nxt_state.instr_div = state_ff.instr_div + 2'h1;
        end
        // count, trigger clears; trigger never sets the flag
        if (i_compare_module_trigger)
        begin
            nxt_state.count = 16'h0000;
        end
        else if (pre_tick && state_ff.control[`BIT_RUN])
        begin
            nxt_state.count = state_ff.count + 16'h0001;
            if (state_ff.count == 16'hffff)
            begin
                nxt_state.flag = 1'b1;
            end
        end
        // register writes override the trigger and count
        if (wr)
        begin
            case (i_paddr)
                `ADDR_CONTROL:
                begin
                    nxt_state.control = {i_pwdata[7], 1'b0, i_pwdata[5:0]};
                end
                `ADDR_COUNT_LOW:
                begin
                    nxt_state.count[7:0] = i_pwdata[7:0];
                    if (state_ff.control[`BIT_WIDE])
                    begin
                        nxt_state.count[15:8] = state_ff.high_buffer;
                    end
                end
                `ADDR_COUNT_HIGH:
                begin
                    if (state_ff.control[`BIT_WIDE])
                    begin
                        nxt_state.high_buffer = i_pwdata[7:0];
                    end
                    else
                    begin
                        nxt_state.count[15:8] = i_pwdata[7:0];
                    end
                end
                `ADDR_IRQ:
                begin
                    // write 0 clears, write 1 keeps; a same-cycle overflow wins
                    nxt_state.flag = ovf_set || (state_ff.flag && i_pwdata[`BIT_FLAG]);
                    nxt_state.irq_enable = i_pwdata[`BIT_IRQ_ENABLE];
                end
                default:
                begin
                    nxt_state.irq_enable = state_ff.irq_enable;
                end
            endcase
        end
        // reads: decoded in the first access cycle, held through the wait state;
        // in wide mode the low byte read latches the live high byte only once per access
        nxt_state.rd_wait = rd && !state_ff.rd_wait;
        if (!rd)
        begin
            nxt_state.rdata = 32'h0;
        end
        else if (!state_ff.rd_wait)
        begin
            nxt_state.rdata = 32'h0;
            case (i_paddr)
                `ADDR_CONTROL:
                begin
                    nxt_state.rdata[7:0] = {state_ff.control[7], state_ff.sysclk_status,
                                            state_ff.control[5:0]};
                end
                `ADDR_COUNT_LOW:
                begin
                    nxt_state.rdata[7:0] = state_ff.count[7:0];
                    if (state_ff.control[`BIT_WIDE])
                    begin
                        nxt_state.high_buffer = state_ff.count[15:8];
                    end
                end
                `ADDR_COUNT_HIGH:
                begin
                    nxt_state.rdata[7:0] = state_ff.control[`BIT_WIDE] ? state_ff.high_buffer
                                                                      : state_ff.count[15:8];
                end
                `ADDR_IRQ:
                begin
                    nxt_state.rdata[1:0] = {state_ff.irq_enable, state_ff.flag};
                end
                default:
                begin
                    nxt_state.rdata = 32'h0;
                end
            endcase
        end
    end

    // rdata is registered in the first access cycle and stands at the ready edge
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // oscillator and interrupt outputs
    // ------------------------------------------------------------------
    // run request ignores power-managed mode on purpose
    assign o_crystal_osc_run = state_ff.control[`BIT_OSC_ENABLE];
    assign o_osc_pins_force_input = state_ff.control[`BIT_OSC_ENABLE];
    assign o_osc_pins_read_zero = state_ff.control[`BIT_OSC_ENABLE];
    assign o_overflow_irq = state_ff.flag && state_ff.irq_enable;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_trigger_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_compare_module_trigger && !wr |=> state_ff.count == 16'h0000)
        else $error("trigger did not clear count");
    a_stopped_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !state_ff.control[`BIT_RUN] && !wr && !i_compare_module_trigger
        |=> $stable(state_ff.count))
        else $error("stopped counter moved");
    a_overflow_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        pre_tick && state_ff.control[`BIT_RUN] && state_ff.count == 16'hffff
        && !i_compare_module_trigger && !wr |=> state_ff.flag)
        else $error("overflow did not set flag");
    a_flag_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ovf_set |=> state_ff.flag)
        else $error("overflow lost to a flag clear");
    a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ovf_set && state_ff.irq_enable && !wr |=> o_overflow_irq)
        else $error("enabled overflow raised no irq");
    a_wide_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        rd && !state_ff.rd_wait && i_paddr == `ADDR_COUNT_LOW && state_ff.control[`BIT_WIDE]
        |=> state_ff.high_buffer == $past(state_ff.count[15:8]))
        else $error("high buffer not latched");
    a_wide_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        low_wr && state_ff.control[`BIT_WIDE]
        |=> state_ff.count[15:8] == $past(state_ff.high_buffer))
        else $error("high byte not loaded from buffer");
    a_write_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        low_wr && i_compare_module_trigger
        |=> state_ff.count[7:0] == $past(i_pwdata[7:0]))
        else $error("trigger beat software write");
    a_status_ro: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 state_ff.control[`BIT_SYSCLK_STATUS] == 1'b0)
        else $error("status bit stored in control");
    a_pins_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_ff.control[`BIT_OSC_ENABLE] |-> o_osc_pins_read_zero && o_crystal_osc_run)
        else $error("pins not forced with oscillator on");
    a_osc_in_pm: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_power_managed && state_ff.control[`BIT_OSC_ENABLE] |-> o_crystal_osc_run)
        else $error("oscillator stopped in power-managed mode");

    // a read is held off one cycle, then answered with the data standing
    sequence s_read_first;
        rd && !state_ff.rd_wait;
    endsequence
    sequence s_read_answer;
        rd && o_pready;
    endsequence
    a_read_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_read_first |-> !o_pready ##1 s_read_answer)
        else $error("read not answered after one wait state");
endmodule

// ===== core/timer_one_params.svh
// offsets, field positions and reset values of the timer block
// assumes an apb slave with 32-bit data and word-aligned registers
`ifndef TIMER_ONE_PARAMS_SVH
`define TIMER_ONE_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CONTROL 12'h000
`define ADDR_COUNT_LOW 12'h004
`define ADDR_COUNT_HIGH 12'h008
`define ADDR_IRQ 12'h00c

// ----------------------------------------------------------------------
// control and irq register fields
// ----------------------------------------------------------------------
`define BIT_RUN 0
`define BIT_SOURCE 1
`define BIT_SYNC_BYPASS 2
`define BIT_OSC_ENABLE 3
`define BIT_PRESCALE_LO 4
`define BIT_PRESCALE_HI 5
`define BIT_SYSCLK_STATUS 6
`define BIT_WIDE 7
`define BIT_FLAG 0
`define BIT_IRQ_ENABLE 1
`define CONTROL_RESET 8'h00

`endif

// ===== core/timer_one_pkg.sv
// types shared by the timer block
// assumes nothing of its surroundings
package timer_one_pkg;
    typedef enum logic [1:0] {
        PRESCALE_1,
        PRESCALE_2,
        PRESCALE_4,
        PRESCALE_8
    } prescale_t;
endpackage

// ===== core/input_sync3.sv
// three-stage synchroniser for an input from outside the clock domain
// assumes a free-running system clock
`timescale 1ns/1ps
module input_sync3
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // asynchronous input
    input wire logic i_async,
    // filtered level
    output logic o_level
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // level only changes once stages two and three agree
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.stage = {state_ff.stage[1:0], i_async};
        if (state_ff.stage[1] == state_ff.stage[2])
        begin
            nxt_state.level = state_ff.stage[2];
        end
    end

    // register the copy
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign o_level = state_ff.level;
endmodule

// ===== core/count_prescaler.sv
// prescaler dividing count ticks by 1, 2, 4 or 8
// assumes ticks are one-cycle pulses on the system clock
`timescale 1ns/1ps
module count_prescaler
    import timer_one_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // control
    input wire prescale_t i_ratio,
    input wire logic i_clear,
    input wire logic i_tick,
    // divided tick
    output logic o_tick
);
    typedef struct packed {
        logic [2:0] count;
    } pre_state_t;

    pre_state_t state_ff;
    pre_state_t nxt_state;
    logic [2:0] limit;

    // terminal count from ratio code
    always_comb
    begin
        case (i_ratio)
            PRESCALE_1: limit = 3'h0;
            PRESCALE_2: limit = 3'h1;
            PRESCALE_4: limit = 3'h3;
            PRESCALE_8: limit = 3'h7;
            default: limit = 3'h0;
        endcase
    end

    // divided tick is combinational so the counter sees it at once
    assign o_tick = i_tick && !i_clear && (state_ff.count >= limit);

    // count ticks; clear wins over a tick
    always_comb
    begin
        nxt_state = state_ff;
        if (i_clear)
        begin
            nxt_state.count = 3'h0;
        end
        else if (i_tick)
        begin
            if (state_ff.count >= limit)
            begin
                nxt_state.count = 3'h0;
            end
            else
            begin
                nxt_state.count = state_ff.count + 3'h1;
            end
        end
    end

    // register the copy
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end
endmodule

// ===== bench/ext_clock_source.sv
// far-side model: external count clock pin and the watch crystal output
// assumes the bench pulses i_go for one cycle with i_sel and i_edges steady
`timescale 1ns/1ps
module ext_clock_source
#(
    parameter int HALF = 8
)
(
    // clock
    input wire logic i_sys_clk,
    // burst request
    input wire logic i_go,
    input wire logic i_sel,
    input wire logic [7:0] i_edges,
    // clock lines and status
    output logic o_pin,
    output logic o_xtal,
    output logic o_busy
);
    // ------------------------------------------------------------------
    // burst generator
    // ------------------------------------------------------------------
    // lines stand low between bursts; half period well above the sync depth
    initial
    begin
        o_pin = 1'b0;
        o_xtal = 1'b0;
        o_busy = 1'b0;
    end
    always @(posedge i_sys_clk)
    begin
        if (i_go && !o_busy)
        begin
            o_busy <= 1'b1;
            for (int k = 0; k < 2 * i_edges; k++)
            begin
                repeat (HALF) @(posedge i_sys_clk);
                if (i_sel)
                    o_xtal <= ~o_xtal;
                else
                    o_pin <= ~o_pin;
            end
            repeat (HALF) @(posedge i_sys_clk);
            o_busy <= 1'b0;
        end
    end
endmodule

// ===== bench/tb_sixteen_bit_timer_counter.sv
// self-checking bench for the timer block over apb
// assumes an apb slave that may insert wait states; data taken at the ready edge
`timescale 1ns/1ps
`include "timer_one_params.svh"
module tb_sixteen_bit_timer_counter;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic ext_pin, xtal, trig, trig_acc, sysosc, pm, go, sel, busy;
    logic osc_run, force_in, read_zero, irq, e;
    logic [7:0] edges;
    int n_errors, n_compared;

    // 250 MHz clock
    always #2 clk = ~clk;

    sixteen_bit_timer_counter #(.INSTR_DIV(4)) i_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ext_count_clock_pin(ext_pin), .i_crystal_in_pin(xtal),
        .i_compare_module_trigger(trig), .i_sysclk_from_osc(sysosc),
        .i_power_managed(pm), .o_crystal_osc_run(osc_run),
        .o_osc_pins_force_input(force_in), .o_osc_pins_read_zero(read_zero),
        .o_overflow_irq(irq));

    ext_clock_source #(.HALF(8)) i_src (.i_sys_clk(clk), .i_go(go), .i_sel(sel),
        .i_edges(edges), .o_pin(ext_pin), .o_xtal(xtal), .o_busy(busy));

    // ------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------
    // trigger may be raised in the access cycle to collide with a write
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        trig <= trig_acc;
        // data and error are taken at the edge where ready is seen high
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        trig <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic x;
        apb(1'b1, a, {24'h0, d}, q, x);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic x;
        apb(1'b0, a, 32'h0, q, x);
    endtask
    task automatic chkr(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            $display("wrong value t=%0t got=%h exp=%h", $time, got, lo);
            n_errors++;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        chkr(got, exp, exp);
    endtask
    // byte-mode read of both halves; only meaningful while stopped
    task automatic cnt(output logic [31:0] c);
        logic [31:0] l, h;
        rd(`ADDR_COUNT_LOW, l);
        rd(`ADDR_COUNT_HIGH, h);
        c = {16'h0, h[7:0], l[7:0]};
    endtask
    task automatic setc(input logic [7:0] h, input logic [7:0] l);
        wr(`ADDR_COUNT_HIGH, h);
        wr(`ADDR_COUNT_LOW, l);
    endtask
    task automatic burst(input logic s, input logic [7:0] n);
        int k;
        @(posedge clk);
        sel <= s;
        edges <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 3000 && busy !== 1'b0; k++)
            @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(`ADDR_CONTROL, v);
        chk(v, 32'h0);
        cnt(v);
        chk(v, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("reset values done");
    endtask
    task automatic t_bytes;
        setc(8'h12, 8'h34);
        cnt(v);
        chk(v, 32'h1234);
        repeat (40) @(posedge clk);
        cnt(v);
        chk(v, 32'h1234);
        $display("byte access done");
    endtask
    task automatic t_prescale;
        for (int p = 0; p < 4; p++)
        begin
            setc(8'h00, 8'h00);
            wr(`ADDR_CONTROL, {2'b00, p[1:0], 4'h1});
            repeat (64 << p) @(posedge clk);
            wr(`ADDR_CONTROL, 8'h00);
            cnt(v);
            chkr(v, 32'd15, 32'd17);
        end
        $display("prescale done");
    endtask
    task automatic t_overflow;
        setc(8'hff, 8'hff);
        wr(`ADDR_CONTROL, 8'h01);
        repeat (20) @(posedge clk);
        wr(`ADDR_CONTROL, 8'h00);
        cnt(v);
        chkr(v, 32'd1, 32'd7);
        rd(`ADDR_IRQ, v);
        chk(v, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`ADDR_IRQ, 8'h03);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ, 8'h02);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("overflow done");
    endtask
    task automatic t_wide;
        setc(8'h11, 8'h22);
        wr(`ADDR_CONTROL, 8'h80);
        wr(`ADDR_COUNT_HIGH, 8'h77);
        wr(`ADDR_CONTROL, 8'h00);
        rd(`ADDR_COUNT_HIGH, v);
        chk(v, 32'h11);
        wr(`ADDR_CONTROL, 8'h80);
        rd(`ADDR_COUNT_LOW, v);
        chk(v, 32'h22);
        rd(`ADDR_COUNT_HIGH, v);
        chk(v, 32'h11);
        setc(8'h77, 8'h44);
        wr(`ADDR_CONTROL, 8'h00);
        cnt(v);
        chk(v, 32'h7744);
        $display("wide access done");
    endtask
    task automatic t_external;
        setc(8'h00, 8'h00);
        wr(`ADDR_CONTROL, 8'h03);
        burst(1'b0, 8'd10);
        wr(`ADDR_CONTROL, 8'h00);
        cnt(v);
        chk(v, 32'd10);
        wr(`ADDR_CONTROL, 8'h0e);
        repeat (16) @(posedge clk);
        pm <= 1'b1;
        setc(8'h00, 8'h00);
        wr(`ADDR_CONTROL, 8'h0f);
        @(posedge clk);
        chk({29'h0, osc_run, force_in, read_zero}, 32'h7);
        burst(1'b1, 8'd5);
        wr(`ADDR_CONTROL, 8'h00);
        cnt(v);
        chk(v, 32'd5);
        chk({29'h0, osc_run, force_in, read_zero}, 32'h0);
        pm <= 1'b0;
        $display("external source done");
    endtask
    task automatic t_trigger;
        // start near the top so an enabled overflow happens before the trigger
        setc(8'hff, 8'hf0);
        wr(`ADDR_CONTROL, 8'h01);
        repeat (100) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ, 8'h02);
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        wr(`ADDR_CONTROL, 8'h00);
        cnt(v);
        chkr(v, 32'd0, 32'd2);
        rd(`ADDR_IRQ, v);
        chk(v, 32'h2);
        trig_acc = 1'b1;
        wr(`ADDR_COUNT_LOW, 8'h40);
        trig_acc = 1'b0;
        cnt(v);
        chk(v, 32'h40);
        $display("trigger done");
    endtask
    task automatic t_status_refuse;
        sysosc <= 1'b1;
        wr(`ADDR_CONTROL, 8'h00);
        rd(`ADDR_CONTROL, v);
        chk(v, 32'h40);
        sysosc <= 1'b0;
        wr(`ADDR_CONTROL, 8'h40);
        rd(`ADDR_CONTROL, v);
        chk(v, 32'h0);
        apb(1'b1, 12'h010, 32'hff, v, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h010, 32'h0, v, e);
        chk({31'h0, e}, 32'h1);
        chk(v, 32'h0);
        $display("status and unmapped done");
    endtask

    // ------------------------------------------------------------------
    // verdict and sequencing
    // ------------------------------------------------------------------
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: tests take about 2k cycles, so 50k is ample
    initial
    begin
        #200000;
        n_errors++;
        summarize();
    end
    initial
    begin
        {clk, rst_n, psel, penable, pwrite, trig, trig_acc, sysosc, pm, go, sel} = '0;
        paddr = '0;
        pwdata = '0;
        edges = '0;
        n_errors = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_bytes();
        t_prescale();
        t_overflow();
        t_wide();
        t_external();
        t_trigger();
        t_status_refuse();
        summarize();
    end
endmodule
